// file: core/djc_pkg.sv
/*
 * djc_pkg: constants, state codes and carrier types for the decimal
 * justification control block.
 * Assumes a 32-bit APB slave with word-aligned registers and one system
 * clock domain for everything the block does.
 */
package djc_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_UNITS = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_DPSTORE = 8'h0C;

   // command register bits (write-one pulses)
   localparam int CMD_CLEAR_BIT = 0;
   localparam int CMD_DIGIT_BIT = 1;

   // units register fields
   localparam int UNITS_CODE_LSB = 0;
   localparam int UNITS_TARGET_LSB = 4;

   // status register fields
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_ACTIVE_BIT = 4;
   localparam int ST_FLAG_BIT = 5;
   localparam int ST_EQ_BIT = 6;
   localparam int ST_LT_BIT = 7;
   localparam int ST_STATE_LSB = 8;
   localparam int ST_SEL_LSB = 12;
   localparam int ST_DONE_BIT = 14;

   // counter values and burst length
   localparam logic [3:0] CNT_LOCAL_PRESET = 4'h9;
   localparam logic [3:0] CNT_REMOTE_VALUE = 4'h0;
   localparam logic [3:0] CNT_TOP = 4'h9;
   localparam logic [3:0] BURST_LEN = 4'h9;

   // reset values
   localparam logic [3:0] RST_COUNT = 4'h9;
   localparam logic [3:0] RST_TARGET = 4'h9;
   localparam logic [1:0] RST_UNITS = 2'h0;
   localparam logic [3:0] RST_DP_WORD = 4'h0;

   // units codes
   typedef enum logic [1:0] {
      UNITS_HZ = 2'b00,
      UNITS_KHZ = 2'b01,
      UNITS_MHZ = 2'b10,
      UNITS_GHZ = 2'b11
   } djc_units_t;

   // decimal-point store word select
   typedef enum logic [1:0] {
      SEL_CENTRE = 2'b00,
      SEL_SWEEP = 2'b01,
      SEL_STEP = 2'b10,
      SEL_KEYBOARD = 2'b11
   } djc_sel_t;

   // control states, named after the flow-graph states they stand for
   typedef enum logic [3:0] {
      ST_IDLE_0_0 = 4'b0000,
      ST_JUST_1_6 = 4'b0001,
      ST_DIGIT_3_5 = 4'b0010,
      ST_6_14 = 4'b0011,
      ST_1_1 = 4'b0100,
      ST_4_1 = 4'b0101,
      ST_1_9 = 4'b0110,
      ST_4_9 = 4'b0111,
      ST_4_10 = 4'b1000,
      ST_5_10 = 4'b1001
   } djc_state_t;

   typedef struct packed {
      logic local_sel;
      logic keyboard_view_button;
      logic step_button;
      logic sweep_width_button;
   } djc_panel_t;

   typedef struct packed {
      logic hz;
      logic khz;
      logic m;
      logic ghz;
   } djc_lamps_t;

endpackage : djc_pkg

// file: core/djc_top.sv
/*
 * djc_top: keyboard-entry justification counter and sequencer, decimal-point
 * store, one-of-ten decimal-point decoder and units-lamp gating, with an APB
 * register slave.
 * Assumes panel inputs are asynchronous pins and the keyboard register lives
 * outside, shifted once per low cycle of keyboard_shift_clock_n.
 */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps

// What this block does
// - hold in justify state until satisfied
// - each burst stops after nine pulses
// - comparator equality marks justification satisfied
// - completion captured at tenth clock, drops active on equal
// - fixed state walk back to idle
// - units key restarts on held entry
// - target below counter: nine-pulse bursts
// - target above: completion input held high
// - right shift single steps, drop on equal
// - shift clocks issued during every count
// - four-word store, two-bit select
// - store select from buttons, centre default
// - remote shows centre frequency in MHz
// - remote forces counter to zero
// - one-of-ten decoder, active-low outputs
// - Hz, kHz, M, GHz lamps; MHz uses two
// - lamps off until entry justified
// - local preset counter to nine
// - each decimal digit lowers counter one
module djc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire djc_pkg::djc_panel_t panel_in,
   output logic justify_active,
   output logic keyboard_shift_clock_n,
   output logic entry_justified_flag_n,
   output logic [9:0] dp_sel_n,
   output djc_pkg::djc_lamps_t lamps
);

   djc_pkg::djc_panel_t sync1_q;
   djc_pkg::djc_panel_t panel_q;
   djc_pkg::djc_state_t state_q;
   djc_pkg::djc_state_t state_d;
   logic [3:0] count_q;
   logic [3:0] count_d;
   logic [3:0] target_q;
   logic [1:0] units_q;
   logic [3:0] burst_q;
   logic [3:0] burst_d;
   logic done_q;
   logic done_d;
   logic kck_d;
   logic [3:0] dp_store_q [4];
   logic [1:0] sel;
   logic [1:0] units_eff;
   logic cmp_eq;
   logic cmp_lt;
   logic wr_en;
   logic rd_setup;
   logic cmd_clear;
   logic cmd_digit;
   logic units_key;
   logic wr_cmd;
   logic [3:0] count_step;
   logic [3:0] dp_word;
   logic [31:0] rd_mux;
   logic rd_err;

   // two flops on every panel pin before anything looks at it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         panel_q <= '0;
      end else begin
         sync1_q <= panel_in;
         panel_q <= sync1_q;
      end
   end

   // APB: read data captured in setup so pready can come from a flop
   assign rd_setup = psel && !penable;
   // a write lands at the edge that ends the one access cycle
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   assign wr_cmd = wr_en && (paddr == djc_pkg::OFF_CMD);
   assign cmd_clear = wr_cmd && pwdata[djc_pkg::CMD_CLEAR_BIT];
   assign cmd_digit = wr_cmd && pwdata[djc_pkg::CMD_DIGIT_BIT];
   assign units_key = wr_en && (paddr == djc_pkg::OFF_UNITS);

   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      if (paddr == djc_pkg::OFF_CMD) begin
         rd_mux = '0;
      end else if (paddr == djc_pkg::OFF_UNITS) begin
         rd_mux[djc_pkg::UNITS_CODE_LSB +: 2] = units_q;
         rd_mux[djc_pkg::UNITS_TARGET_LSB +: 4] = target_q;
      end else if (paddr == djc_pkg::OFF_STATUS) begin
         rd_mux[djc_pkg::ST_COUNT_LSB +: 4] = count_q;
         rd_mux[djc_pkg::ST_ACTIVE_BIT] = justify_active;
         rd_mux[djc_pkg::ST_FLAG_BIT] = entry_justified_flag_n;
         rd_mux[djc_pkg::ST_EQ_BIT] = cmp_eq;
         rd_mux[djc_pkg::ST_LT_BIT] = cmp_lt;
         rd_mux[djc_pkg::ST_STATE_LSB +: 4] = state_q;
         rd_mux[djc_pkg::ST_SEL_LSB +: 2] = sel;
         rd_mux[djc_pkg::ST_DONE_BIT] = done_q;
      end else if (paddr == djc_pkg::OFF_DPSTORE) begin
         rd_mux = {16'h0000, dp_store_q[3], dp_store_q[2], dp_store_q[1], dp_store_q[0]};
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_setup;
         // an unmapped offset answers with an error and writes nothing
         pslverr <= rd_setup && rd_err;
         if (rd_setup && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // units register: a write is a units key press
   // remote refuses units keys; the readout is pinned to MHz there
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         units_q <= djc_pkg::RST_UNITS;
         target_q <= djc_pkg::RST_TARGET;
      end else if (units_key && state_q == djc_pkg::ST_IDLE_0_0 && panel_q.local_sel) begin
         units_q <= pwdata[djc_pkg::UNITS_CODE_LSB +: 2];
         target_q <= pwdata[djc_pkg::UNITS_TARGET_LSB +: 4];
      end
   end

   // remote forces centre frequency and MHz
   always_comb begin
      if (!panel_q.local_sel) begin
         sel = djc_pkg::SEL_CENTRE;
         units_eff = djc_pkg::UNITS_MHZ;
      end else if (panel_q.keyboard_view_button) begin
         sel = djc_pkg::SEL_KEYBOARD;
         units_eff = units_q;
      end else if (panel_q.step_button) begin
         sel = djc_pkg::SEL_STEP;
         units_eff = units_q;
      end else if (panel_q.sweep_width_button) begin
         sel = djc_pkg::SEL_SWEEP;
         units_eff = units_q;
      end else begin
         sel = djc_pkg::SEL_CENTRE;
         units_eff = units_q;
      end
   end

   assign cmp_eq = (count_q == target_q);
   assign cmp_lt = (count_q < target_q);
   // up-counting decade step, nine wraps to zero
   assign count_step = (count_q == djc_pkg::CNT_TOP) ? 4'h0 : count_q + 4'h1;

   // sequencer and justification counter
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      burst_d = burst_q;
      done_d = done_q;
      kck_d = 1'b0;
      case (state_q)
         djc_pkg::ST_IDLE_0_0: begin
            burst_d = '0;
            // clear wins over a digit written in the same word
            if (cmd_clear) begin
               count_d = djc_pkg::CNT_LOCAL_PRESET;
               done_d = 1'b0;
            end else if (cmd_digit) begin
               state_d = djc_pkg::ST_DIGIT_3_5;
            end else if (units_key) begin
               // the held entry is justified again, nothing re-keyed
               state_d = djc_pkg::ST_JUST_1_6;
            end
         end
         djc_pkg::ST_DIGIT_3_5: begin
            // nine decade steps leave the counter one lower
            count_d = count_step;
            kck_d = 1'b1;
            burst_d = burst_q + 4'h1;
            if (burst_q == djc_pkg::BURST_LEN - 4'h1) begin
               state_d = djc_pkg::ST_IDLE_0_0;
            end
         end
         djc_pkg::ST_JUST_1_6: begin
            if (burst_q == djc_pkg::BURST_LEN) begin
               // tenth clock: completion flop samples the compare
               done_d = cmp_eq || cmp_lt;
               burst_d = '0;
               if (cmp_eq) begin
                  state_d = djc_pkg::ST_6_14;
               end
            end else if (burst_q != 4'h0) begin
               count_d = count_step;
               kck_d = 1'b1;
               burst_d = burst_q + 4'h1;
            end else if (cmp_eq) begin
               done_d = 1'b1;
               state_d = djc_pkg::ST_6_14;
            end else if (cmp_lt) begin
               // right shift: single clocks, completion flop held high
               done_d = 1'b1;
               count_d = count_q + 4'h1;
               kck_d = 1'b1;
            end else begin
               // first pulse of a left-shift burst: nine pulses, then the check clock
               done_d = 1'b0;
               count_d = count_step;
               kck_d = 1'b1;
               burst_d = 4'h1;
            end
         end
         djc_pkg::ST_6_14: begin
            state_d = djc_pkg::ST_1_1;
         end
         djc_pkg::ST_1_1: begin
            state_d = djc_pkg::ST_4_1;
         end
         djc_pkg::ST_4_1: begin
            state_d = djc_pkg::ST_1_9;
         end
         djc_pkg::ST_1_9: begin
            state_d = djc_pkg::ST_4_9;
         end
         djc_pkg::ST_4_9: begin
            state_d = djc_pkg::ST_4_10;
         end
         djc_pkg::ST_4_10: begin
            state_d = djc_pkg::ST_5_10;
         end
         djc_pkg::ST_5_10: begin
            state_d = djc_pkg::ST_IDLE_0_0;
         end
         default: begin
            state_d = djc_pkg::ST_IDLE_0_0;
         end
      endcase
      if (!panel_q.local_sel) begin
         // remote has no entry to justify; counter pinned at zero
         count_d = djc_pkg::CNT_REMOTE_VALUE;
         state_d = djc_pkg::ST_IDLE_0_0;
         burst_d = '0;
         kck_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= djc_pkg::ST_IDLE_0_0;
         count_q <= djc_pkg::RST_COUNT;
         burst_q <= '0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         burst_q <= burst_d;
         done_q <= done_d;
      end
   end

   // outputs registered; active follows the next state so it drops on exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         justify_active <= 1'b0;
         keyboard_shift_clock_n <= 1'b1;
      end else begin
         justify_active <= (state_d == djc_pkg::ST_JUST_1_6);
         keyboard_shift_clock_n <= !kck_d;
      end
   end

   // entry flag: high from a clear or the first keyed digit until justified
   // refused commands (busy or remote) leave the flag as it is
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         entry_justified_flag_n <= 1'b0;
      end else if (state_q == djc_pkg::ST_6_14) begin
         entry_justified_flag_n <= 1'b0;
      end else if ((cmd_clear || cmd_digit) && state_q == djc_pkg::ST_IDLE_0_0 && panel_q.local_sel) begin
         entry_justified_flag_n <= 1'b1;
      end
   end

   // decimal-point store, one generate entry per word
   // remote keeps writing the pinned zero count into the centre word
   for (genvar w = 0; w < 4; w++) begin : g_dp_word
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dp_store_q[w] <= djc_pkg::RST_DP_WORD;
         end else if (sel == 2'(w) && (state_q == djc_pkg::ST_6_14 || !panel_q.local_sel)) begin
            dp_store_q[w] <= count_q;
         end
      end
   end

   // the shown word follows the same select as the writes
   assign dp_word = dp_store_q[sel];

   // one-of-ten decoder; codes above nine light no point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp_sel_n <= '1;
      end else begin
         for (int i = 0; i < 10; i++) begin
            dp_sel_n[i] <= (dp_word != 4'(i));
         end
      end
   end

   // units lamps, held dark while an entry is shown unjustified
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamps <= '0;
      end else if (entry_justified_flag_n) begin
         lamps <= '0;
      end else begin
         lamps.hz <= (units_eff == djc_pkg::UNITS_HZ) || (units_eff == djc_pkg::UNITS_MHZ);
         lamps.khz <= (units_eff == djc_pkg::UNITS_KHZ);
         lamps.m <= (units_eff == djc_pkg::UNITS_MHZ);
         lamps.ghz <= (units_eff == djc_pkg::UNITS_GHZ);
      end
   end

endmodule : djc_top

// file: dv/djc_sva.sv
/* djc_sva: port checks for djc_top.
   assumes pclk only, async active-low presetn. */
`timescale 1ns/100ps
module djc_sva (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   input djc_pkg::djc_panel_t panel_in,
   input logic justify_active,
   input logic keyboard_shift_clock_n,
   input logic entry_justified_flag_n,
   input logic [9:0] dp_sel_n,
   input djc_pkg::djc_lamps_t lamps
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] low_run_q;
   // saturates so a stuck shift clock cannot wrap back into range
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_run_q <= 4'h0;
      end else if (keyboard_shift_clock_n) begin
         low_run_q <= 4'h0;
      end else if (low_run_q != 4'hf) begin
         low_run_q <= low_run_q + 4'h1;
      end
   end
   sequence remote_held;
      !panel_in.local_sel [*8];
   endsequence
   sequence exit_quiet;
      keyboard_shift_clock_n [*7];
   endsequence
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_no_wait_a: assert property (psel && !penable |=> pready)
      else $error("pready late");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   burst_max_nine_a: assert property (low_run_q <= 4'h9)
      else $error("shift run over nine");
   dp_one_low_a: assert property ($countones(~dp_sel_n) <= 1)
      else $error("two decimal points lit");
   mhz_two_lamps_a: assert property (lamps.m |-> lamps.hz)
      else $error("M lamp without Hz lamp");
   lamps_inhibit_a: assert property (entry_justified_flag_n && $past(entry_justified_flag_n) |-> lamps == 4'h0)
      else $error("lamps lit during entry");
   done_flag_low_a: assert property ($fell(justify_active) |=> !entry_justified_flag_n)
      else $error("flag not low after justify");
   exit_no_shift_a: assert property ($fell(justify_active) |=> exit_quiet)
      else $error("shift during exit walk");
   remote_mhz_a: assert property (remote_held |-> lamps == 4'ha && dp_sel_n == 10'h3fe)
      else $error("remote display wrong");
endmodule : djc_sva
bind djc_top djc_sva u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .panel_in(panel_in), .justify_active(justify_active),
   .keyboard_shift_clock_n(keyboard_shift_clock_n), .entry_justified_flag_n(entry_justified_flag_n),
   .dp_sel_n(dp_sel_n), .lamps(lamps)
);

// file: dv/djc_panel_model.sv
/* djc_panel_model: front panel levels, keyboard register step count, lit point.
   assumes one shift step per low cycle of the shift clock. */
`timescale 1ns/100ps
module djc_panel_model (
   input logic pclk,
   input djc_pkg::djc_panel_t press,
   input logic keyboard_shift_clock_n,
   input logic [9:0] dp_sel_n,
   output djc_pkg::djc_panel_t panel_in,
   output logic [15:0] shift_count,
   output logic [3:0] dp_pos
);
   djc_pkg::djc_panel_t level_q = 4'h8;
   logic [15:0] steps_q = 16'h0000;
   assign panel_in = level_q;
   assign shift_count = steps_q;
   always @(posedge pclk) begin
      level_q <= press;
      if (!keyboard_shift_clock_n) begin
         steps_q <= steps_q + 16'h0001;
      end
   end
   // 4'hf when dark; a clash is left to the checker
   always_comb begin
      dp_pos = 4'hf;
      for (int i = 0; i < 10; i++) begin
         if (!dp_sel_n[i]) begin
            dp_pos = 4'(i);
         end
      end
   end
endmodule : djc_panel_model

// file: dv/djc_top_tb.sv
/* djc_top_tb: directed bench for djc_top.
   assumes the zero-wait APB slave and panel model beside it. */
`timescale 1ns/100ps
module djc_top_tb;
   typedef struct packed {
      logic clr;
      logic [3:0] nd;
      logic [1:0] u;
      logic [3:0] tgt;
      logic [7:0] sh;
      logic [3:0] lmp;
   } djc_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q;
   logic pready, pslverr, e, justify_active, keyboard_shift_clock_n, entry_justified_flag_n;
   djc_pkg::djc_panel_t panel_in;
   djc_pkg::djc_panel_t press = 4'h8;
   logic [9:0] dp_sel_n;
   djc_pkg::djc_lamps_t lamps;
   logic [15:0] shift_count, base;
   logic [3:0] dp_pos;
   int n_errors = 0;
   int n_compared = 0;
   djc_row_t rows [5] = '{
      '{1'h1, 4'h3, 2'h1, 4'h6, 8'h1b, 4'h4},
      '{1'h0, 4'h0, 2'h2, 4'h3, 8'h1b, 4'ha},
      '{1'h0, 4'h0, 2'h1, 4'h6, 8'h03, 4'h4},
      '{1'h1, 4'h0, 2'h3, 4'h9, 8'h00, 4'h1},
      '{1'h1, 4'h1, 2'h0, 4'h0, 8'h51, 4'h8}
   };
   djc_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .panel_in(panel_in), .justify_active(justify_active),
      .keyboard_shift_clock_n(keyboard_shift_clock_n), .entry_justified_flag_n(entry_justified_flag_n),
      .dp_sel_n(dp_sel_n), .lamps(lamps)
   );
   djc_panel_model u_panel (
      .pclk(pclk), .press(press), .keyboard_shift_clock_n(keyboard_shift_clock_n),
      .dp_sel_n(dp_sel_n), .panel_in(panel_in), .shift_count(shift_count), .dp_pos(dp_pos)
   );
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // polls the state field; commands are only legal in idle
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, djc_pkg::OFF_STATUS, 32'h0000_0000);
         n++;
      end while (q[11:8] !== 4'h0 && n < 100);
      if (q[11:8] !== 4'h0) begin
         n_errors++;
         wrap_up();
      end
   endtask : wait_idle
   initial begin
      repeat (100000) @(posedge pclk);
      n_errors++;
      wrap_up();
   end
   initial begin
      #12;
      chk(32'(lamps), 32'h0000_0000);
      chk(32'(justify_active), 32'h0000_0000);
      chk(32'(keyboard_shift_clock_n), 32'h0000_0001);
      chk(32'(dp_sel_n), 32'h0000_03ff);
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      $display("reset test done");
      foreach (rows[i]) begin
         base = shift_count;
         if (rows[i].clr) begin
            apb(1'b1, djc_pkg::OFF_CMD, 32'h0000_0001);
            wait_idle();
         end
         for (int k = 0; k < rows[i].nd; k++) begin
            apb(1'b1, djc_pkg::OFF_CMD, 32'h0000_0002);
            wait_idle();
         end
         apb(1'b1, djc_pkg::OFF_UNITS, {24'h00_0000, rows[i].tgt, 2'h0, rows[i].u});
         wait_idle();
         chk(32'(q[3:0]), 32'(rows[i].tgt));
         chk(32'(q[6]), 32'h0000_0001);
         chk(32'(q[14]), 32'h0000_0001);
         chk(32'(16'(shift_count - base)), 32'(rows[i].sh));
         chk(32'(lamps), 32'(rows[i].lmp));
         chk(32'(entry_justified_flag_n), 32'h0000_0000);
         chk(32'(dp_pos), 32'(rows[i].tgt));
         $display("row %0d done", i);
      end
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      apb(1'b0, djc_pkg::OFF_CMD, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      $display("address test done");
      for (int k = 1; k < 4; k++) begin
         press <= 4'h8 | 4'(1 << (k - 1));
         repeat (4) @(posedge pclk);
         apb(1'b0, djc_pkg::OFF_STATUS, 32'h0000_0000);
         chk(32'(q[13:12]), 32'(k));
      end
      press <= 4'h9;
      repeat (4) @(posedge pclk);
      apb(1'b1, djc_pkg::OFF_UNITS, 32'h0000_0050);
      wait_idle();
      apb(1'b0, djc_pkg::OFF_DPSTORE, 32'h0000_0000);
      chk(32'(q[15:0]), 32'h0000_0050);
      chk(32'(dp_pos), 32'h0000_0005);
      $display("store test done");
      press <= 4'h0;
      repeat (8) @(posedge pclk);
      chk(32'(lamps), 32'h0000_000a);
      chk(32'(dp_sel_n), 32'h0000_03fe);
      apb(1'b1, djc_pkg::OFF_UNITS, 32'h0000_0061);
      apb(1'b0, djc_pkg::OFF_STATUS, 32'h0000_0000);
      chk(32'(q[3:0]), 32'h0000_0000);
      chk(32'(q[13:8]), 32'h0000_0000);
      chk(32'(justify_active), 32'h0000_0000);
      press <= 4'h8;
      $display("remote test done");
      wrap_up();
   end
endmodule : djc_top_tb
